// File: verilog/acs_sequencer.sv
`timescale 1ns/10ps
`include "acs_regs.svh"
// Contract
// - falling edge on filter-alignment strobe resets filter and sequencing state
// - every calibration command resets the digital filter
// - offset coefficient is subtracted first, difference then multiplied by full scale
// - arithmetic runs at 33 bits, delivered word is 24 or 16 bits
// - host may write offset and full-scale coefficients
// - ready output goes low when self, system or system-offset calibration ends
// - ready rises within one modulator cycle of a calibration command
// - code 001 starts self-calibration through the selected gain stage
// - self-cal converts shorted node, then reference, settles, then ready low
// - bipolar self-cal spans midscale to positive full scale
// - code 010 converts analog input as zero point, ready low after
// - code 011 converts analog input as full point, ready low after
// - a lone 010 step updates offset only, slope kept
// - code 100 zero from analog input, full from reference, ready low after
// - code 101 interleaves shorted and reference conversions with normal ones
// - background mode delivers one result per six filter results
// - background mode stays until the mode field changes
// - first background result precedes full-scale update and is invalid
// - unipolar spans transfer endpoints, bipolar midscale to positive full
// - reset loads the control field with its default content
module acs_sequencer
    import acs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // control register write
    input wire logic i_ctrl_wr,
    input wire logic [2:0] i_calib_mode_field,
    input wire logic i_bipolar,
    input wire logic i_word16,
    // coefficient writes
    input wire logic i_ofs_wr,
    input wire logic i_fs_wr,
    input wire logic [23:0] i_coef_data,
    // filter alignment strobe and host read
    input wire logic i_sync_n,
    input wire logic i_rd_done,
    // raw filter results
    input wire logic i_filt_valid,
    input wire logic [23:0] i_filt_data,
    // results and status
    output logic o_result_ready_n,
    output logic [23:0] o_result,
    output logic o_filter_rst,
    output logic [1:0] o_input_sel,
    output logic [23:0] o_offset_coef,
    output logic [23:0] o_fullscale_coef,
    output logic [2:0] o_calib_mode_field,
    output logic o_calibrating
);
    // sequencer state and its next value
    acs_state_rec_type s_r;
    acs_state_rec_type s_nxt;

    // datapath intermediates
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [32:0] scaled;
    logic signed [32:0] coded;
    logic [23:0] word;
    logic [24:0] meas_span;
    logic [47:0] tgt;
    logic [47:0] trial;
    logic [23:0] quo_bit;
    logic is_cal;

    // calibrated result: subtract offset, multiply, 33-bit working value
    always_comb begin
        diff = $signed({i_filt_data[23], i_filt_data}) - $signed({s_r.ofs[23], s_r.ofs});
        prod = diff * $signed({1'b0, s_r.fs});
        scaled = {{5{prod[49]}}, prod[49:22]};
        coded = i_bipolar ? scaled + $signed(`ACS_MIDSCALE) : scaled;
        // clamp to the unsigned code range
        if (coded[32]) begin
            word = 24'h00_0000;
        end else if (coded > $signed(`ACS_CODE_MAX)) begin
            word = 24'hFF_FFFF;
        end else begin
            word = coded[23:0];
        end
        // short word keeps the top 16 bits
        if (i_word16) begin
            word = {8'h00, word[23:8]};
        end
    end

    // span measurement and restoring divider step
    always_comb begin
        meas_span = {1'b0, i_filt_data} - {1'b0, s_r.ofs};
        tgt = i_bipolar ? `ACS_TGT_BIP : `ACS_TGT_UNI;
        // restoring divider: trial subtraction of the shifted span
        trial = s_r.rem - ({24'h00_0000, s_r.span} << s_r.dbit);
        quo_bit = 24'h00_0001 << s_r.dbit;
        is_cal = (i_calib_mode_field != `ACS_MD_NORMAL) && (i_calib_mode_field <= `ACS_MD_BACKGND);
    end

    // next state of the whole sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.frst = 1'b0;
        s_nxt.sync_d = i_sync_n;

        // host has taken the word; a new word landing this cycle wins
        if (i_rd_done) begin
            s_nxt.rdy_n = 1'b1;
        end

        // command write: abort whatever runs and restart from the new mode
        if (i_ctrl_wr) begin
            s_nxt.mode = i_calib_mode_field;
            s_nxt.cnt = 4'h0;
            s_nxt.slot = 3'h0;
            s_nxt.sel = ACS_SEL_ANALOG;
            s_nxt.st = ACS_ST_RUN;
            if (is_cal) begin
                s_nxt.frst = 1'b1;
                s_nxt.rdy_n = 1'b1;
                s_nxt.st = ACS_ST_MEAS;
                s_nxt.stg = ACS_STG_ZERO;
            end
            // per-mode starting node and stage
            unique case (i_calib_mode_field)
                `ACS_MD_SELF: begin
                    s_nxt.sel = ACS_SEL_SHORT;
                end
                `ACS_MD_SYS_FULL: begin
                    s_nxt.stg = ACS_STG_FULL;
                end
                `ACS_MD_BACKGND: begin
                    s_nxt.st = ACS_ST_BG;
                    s_nxt.sel = ACS_SEL_SHORT;
                end
                default: begin
                end
            endcase
        end else if (s_r.sync_d && !i_sync_n) begin
            // filter alignment: restart counting from a known point
            s_nxt.frst = 1'b1;
            s_nxt.cnt = 4'h0;
            s_nxt.slot = 3'h0;
            if (s_r.st == ACS_ST_BG) begin
                s_nxt.sel = ACS_SEL_SHORT;
            end
        end else begin
            unique case (s_r.st)
                // plain conversion: every filter result becomes a word
                ACS_ST_RUN: begin
                    if (i_filt_valid) begin
                        s_nxt.result = word;
                        s_nxt.rdy_n = 1'b0;
                    end
                end
                // measuring: drop settling results, use the last one
                ACS_ST_MEAS: begin
                    if (i_filt_valid && s_r.cnt != `ACS_SETTLE_RESULTS) begin
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end else if (i_filt_valid) begin
                        s_nxt.cnt = 4'h0;
                        unique case (s_r.stg)
                            // zero point becomes the offset coefficient
                            ACS_STG_ZERO: begin
                                s_nxt.ofs = i_filt_data;
                                if (s_r.mode == `ACS_MD_SYS_ZERO) begin
                                    s_nxt.stg = ACS_STG_SETTLE;
                                    s_nxt.sel = ACS_SEL_ANALOG;
                                end else begin
                                    s_nxt.stg = ACS_STG_FULL;
                                    s_nxt.sel = ACS_SEL_REF;
                                end
                            end
                            // full point gives the span; saturate if quotient overflows
                            ACS_STG_FULL: begin
                                s_nxt.span = meas_span[23:0];
                                s_nxt.rem = tgt;
                                s_nxt.quo = 24'h00_0000;
                                s_nxt.dbit = `ACS_DIV_TOP;
                                s_nxt.st = ACS_ST_DIV;
                                if (meas_span[24] || meas_span[23:0] == 24'h00_0000
                                        || tgt >= {meas_span[23:0], 24'h00_0000}) begin
                                    s_nxt.fs = `ACS_FS_SAT;
                                    s_nxt.st = ACS_ST_MEAS;
                                    s_nxt.stg = ACS_STG_SETTLE;
                                    s_nxt.sel = ACS_SEL_ANALOG;
                                end
                            end
                            default: begin
                                // filter resettled on analog input
                                s_nxt.result = word;
                                s_nxt.rdy_n = 1'b0;
                                s_nxt.st = ACS_ST_RUN;
                            end
                        endcase
                    end
                end
                // one quotient bit per clock, most significant first
                ACS_ST_DIV: begin
                    if (!trial[47]) begin
                        s_nxt.rem = trial;
                        s_nxt.quo = s_r.quo | quo_bit;
                    end
                    s_nxt.dbit = s_r.dbit - 5'h01;
                    // last bit: commit the quotient and move on
                    if (s_r.dbit == 5'h00) begin
                        s_nxt.fs = trial[47] ? s_r.quo : (s_r.quo | quo_bit);
                        if (s_r.mode == `ACS_MD_BACKGND) begin
                            s_nxt.st = ACS_ST_BG;
                            s_nxt.sel = ACS_SEL_SHORT;
                        end else begin
                            s_nxt.st = ACS_ST_MEAS;
                            s_nxt.stg = ACS_STG_SETTLE;
                            s_nxt.sel = ACS_SEL_ANALOG;
                        end
                    end
                end
                ACS_ST_BG: begin
                    // background: one delivery per six filter results
                    if (i_filt_valid) begin
                        s_nxt.slot = s_r.slot + 3'h1;
                        s_nxt.sel = ACS_SEL_ANALOG;
                        // shorted slot refreshes the offset
                        if (s_r.slot == 3'h0) begin
                            s_nxt.ofs = i_filt_data;
                        end
                        if (s_r.slot == `ACS_BG_DELIVER_SLOT) begin
                            s_nxt.result = word;
                            s_nxt.rdy_n = 1'b0;
                            s_nxt.sel = ACS_SEL_REF;
                        end
                        // reference slot closes the round and starts the divider
                        if (s_r.slot == `ACS_BG_REF_SLOT) begin
                            s_nxt.slot = 3'h0;
                            s_nxt.sel = ACS_SEL_SHORT;
                            if (!meas_span[24] && meas_span[23:0] != 24'h00_0000
                                    && tgt < {meas_span[23:0], 24'h00_0000}) begin
                                s_nxt.span = meas_span[23:0];
                                s_nxt.rem = tgt;
                                s_nxt.quo = 24'h00_0000;
                                s_nxt.dbit = `ACS_DIV_TOP;
                                s_nxt.st = ACS_ST_DIV;
                            end
                        end
                    end
                end
            endcase
        end

        // host coefficient writes override calibration updates
        if (i_ofs_wr) begin
            s_nxt.ofs = i_coef_data;
        end
        if (i_fs_wr) begin
            s_nxt.fs = i_coef_data;
        end
    end

    // state register
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r.st <= ACS_ST_RUN;
            s_r.stg <= ACS_STG_ZERO;
            s_r.sel <= ACS_SEL_ANALOG;
            s_r.cnt <= 4'h0;
            s_r.slot <= 3'h0;
            s_r.mode <= `ACS_MD_RESET;
            // coefficients start at zero offset and unity gain
            s_r.ofs <= `ACS_OFS_RESET;
            s_r.fs <= `ACS_FS_UNITY;
            s_r.span <= 24'h00_0000;
            s_r.rem <= 48'h0000_0000_0000;
            s_r.quo <= 24'h00_0000;
            s_r.dbit <= 5'h00;
            s_r.result <= 24'h00_0000;
            // ready idles high, no word pending
            s_r.rdy_n <= 1'b1;
            s_r.frst <= 1'b0;
            s_r.sync_d <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state
    assign o_result_ready_n = s_r.rdy_n;
    assign o_result = s_r.result;
    assign o_filter_rst = s_r.frst;
    assign o_input_sel = s_r.sel;
    assign o_offset_coef = s_r.ofs;
    assign o_fullscale_coef = s_r.fs;
    assign o_calib_mode_field = s_r.mode;
    // background dividing is housekeeping, not a host-issued calibration
    assign o_calibrating = (s_r.st == ACS_ST_MEAS)
        || (s_r.st == ACS_ST_DIV && s_r.mode != `ACS_MD_BACKGND);
endmodule

// File: verilog/acs_regs.svh
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
// calibration-mode field codes
`define ACS_MD_NORMAL 3'h0
`define ACS_MD_SELF 3'h1
`define ACS_MD_SYS_ZERO 3'h2
`define ACS_MD_SYS_FULL 3'h3
`define ACS_MD_SYS_OFS 3'h4
`define ACS_MD_BACKGND 3'h5
// control field content after power-up reset
`define ACS_MD_RESET 3'h0
// filter results discarded after an input switch before one is used
`define ACS_SETTLE_RESULTS 4'h3
// background slot layout: slot 0 shorted node, 1..4 analog, 5 reference
`define ACS_BG_LAST_SLOT 3'h5
`define ACS_BG_DELIVER_SLOT 3'h4
`define ACS_BG_REF_SLOT 3'h5
// coefficient reset values and format (full scale is unsigned q2.22)
`define ACS_OFS_RESET 24'h00_0000
`define ACS_FS_UNITY 24'h40_0000
`define ACS_FS_SAT 24'hFF_FFFF
// span dividends: unipolar reference lands on 2^24, bipolar on 2^23 above midscale
`define ACS_TGT_UNI 48'h4000_0000_0000
`define ACS_TGT_BIP 48'h2000_0000_0000
`define ACS_MIDSCALE 33'h0_0080_0000
`define ACS_CODE_MAX 33'h0_00FF_FFFF
`define ACS_DIV_TOP 5'h17
`endif

// File: verilog/acs_pkg.sv
package acs_pkg;
    typedef enum logic [1:0] {ACS_ST_RUN, ACS_ST_MEAS, ACS_ST_DIV, ACS_ST_BG} acs_state_type;
    typedef enum logic [1:0] {ACS_STG_ZERO, ACS_STG_FULL, ACS_STG_SETTLE} acs_stage_type;
    typedef enum logic [1:0] {ACS_SEL_ANALOG, ACS_SEL_SHORT, ACS_SEL_REF} acs_sel_type;
    typedef struct packed {
        acs_state_type st;
        acs_stage_type stg;
        acs_sel_type sel;
        logic [3:0] cnt;
        logic [2:0] slot;
        logic [2:0] mode;
        logic [23:0] ofs;
        logic [23:0] fs;
        logic [23:0] span;
        logic [47:0] rem;
        logic [23:0] quo;
        logic [4:0] dbit;
        logic [23:0] result;
        logic rdy_n;
        logic frst;
        logic sync_d;
    } acs_state_rec_type;
endpackage

// File: testbench/acs_sequencer_monitor.sv
`timescale 1ns/10ps
module acs_sequencer_monitor (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // watched inputs
    input wire logic i_ctrl_wr,
    input wire logic [2:0] i_calib_mode_field,
    input wire logic i_ofs_wr,
    input wire logic i_fs_wr,
    input wire logic [23:0] i_coef_data,
    input wire logic i_sync_n,
    // watched outputs
    input wire logic o_result_ready_n,
    input wire logic o_filter_rst,
    input wire logic [1:0] o_input_sel,
    input wire logic [23:0] o_offset_coef,
    input wire logic [23:0] o_fullscale_coef,
    input wire logic [2:0] o_calib_mode_field,
    input wire logic o_calibrating
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // calibration command of code 1..5
    logic cal_cmd;
    assign cal_cmd = i_ctrl_wr && (i_calib_mode_field inside {[3'h1:3'h5]});
    a_cmd_filt_rst: assert property (cal_cmd |=> o_filter_rst) else $error("no filter reset");
    a_cmd_ready_hi: assert property (cal_cmd |=> o_result_ready_n) else $error("ready low");
    a_sync_filt_rst: assert property ($fell(i_sync_n) && !i_ctrl_wr |=> o_filter_rst)
        else $error("no sync reset");
    a_mode_hold: assert property (!i_ctrl_wr |=> $stable(o_calib_mode_field))
        else $error("mode moved");
    a_mode_load: assert property (cal_cmd |=> o_calib_mode_field == $past(i_calib_mode_field))
        else $error("mode not loaded");
    a_self_short: assert property (i_ctrl_wr && i_calib_mode_field == 3'h1
        |=> o_input_sel == 2'h1 && o_calibrating) else $error("self cal node");
    a_sysofs_input: assert property (i_ctrl_wr && i_calib_mode_field == 3'h4
        |=> o_input_sel == 2'h0 && o_calibrating) else $error("offset cal node");
    a_ofs_write: assert property (i_ofs_wr |=> o_offset_coef == $past(i_coef_data))
        else $error("offset write");
    a_fs_write: assert property (i_fs_wr |=> o_fullscale_coef == $past(i_coef_data))
        else $error("full scale write");
    a_cal_done_rdy: assert property ($fell(o_calibrating) && !$past(i_ctrl_wr)
        |-> !o_result_ready_n) else $error("ready not low at end");
    // main scenarios reached
    c_cal_cmd: cover property (cal_cmd);
    c_cal_done: cover property ($fell(o_calibrating));
    c_bg_out: cover property (o_calib_mode_field == 3'h5 && $fell(o_result_ready_n));
endmodule
bind acs_sequencer acs_sequencer_monitor mon_u (.*);

// File: testbench/acs_far_model.sv
`timescale 1ns/10ps
module acs_far_model #(
    parameter logic [23:0] SHORT_CODE = 24'h00_0100,
    parameter logic [23:0] REF_CODE = 24'h60_0100,
    parameter int PERIOD = 32
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // from the sequencer
    input wire logic [1:0] i_input_sel,
    input wire logic i_filter_rst,
    input wire logic i_ready_n,
    input wire logic [23:0] i_analog,
    // to the sequencer
    output logic o_filt_valid,
    output logic [23:0] o_filt_data,
    output logic o_rd_done
);
    int cnt_r;
    // filter result every period, restarted by filter reset; data bus churns between
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= 0;
            o_filt_valid <= 1'b0;
            o_filt_data <= 24'h00_0000;
            o_rd_done <= 1'b0;
        end else begin
            cnt_r <= (i_filter_rst || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
            o_filt_valid <= (cnt_r == PERIOD - 1) && !i_filter_rst;
            if (cnt_r == PERIOD - 1) begin
                o_filt_data <= (i_input_sel == 2'h1) ? SHORT_CODE :
                    (i_input_sel == 2'h2) ? REF_CODE : i_analog;
            end else begin
                o_filt_data <= ~o_filt_data;
            end
            // host reads each word once; ready right after a read is not acted on
            o_rd_done <= !i_ready_n && !o_rd_done;
        end
    end
endmodule

// File: testbench/acs_sequencer_tb.sv
`timescale 1ns/10ps
module acs_sequencer_tb;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ctrl_wr = 1'b0, i_word16 = 1'b0, i_ofs_wr = 1'b0;
    logic i_fs_wr = 1'b0, i_sync_n = 1'b1, i_rd_done, i_filt_valid, i_bipolar = 1'b0;
    logic [2:0] i_calib_mode_field = 3'h0, o_calib_mode_field;
    logic [23:0] i_coef_data = 24'h00_0000, i_filt_data, analog = 24'h12_3500;
    logic o_result_ready_n, o_filter_rst, o_calibrating;
    logic [23:0] o_result, o_offset_coef, o_fullscale_coef;
    logic [1:0] o_input_sel;
    int mismatches = 0, tests_run = 0;
    // clock
    always #20 i_clk = ~i_clk;
    acs_sequencer dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_ctrl_wr(i_ctrl_wr),
        .i_calib_mode_field(i_calib_mode_field), .i_bipolar(i_bipolar), .i_word16(i_word16),
        .i_ofs_wr(i_ofs_wr), .i_fs_wr(i_fs_wr), .i_coef_data(i_coef_data), .i_sync_n(i_sync_n),
        .i_rd_done(i_rd_done), .i_filt_valid(i_filt_valid), .i_filt_data(i_filt_data),
        .o_result_ready_n(o_result_ready_n), .o_result(o_result), .o_filter_rst(o_filter_rst),
        .o_input_sel(o_input_sel), .o_offset_coef(o_offset_coef),
        .o_fullscale_coef(o_fullscale_coef), .o_calib_mode_field(o_calib_mode_field),
        .o_calibrating(o_calibrating));
    acs_far_model far_u (.i_clk(i_clk), .i_rst(i_rst), .i_input_sel(o_input_sel),
        .i_filter_rst(o_filter_rst), .i_ready_n(o_result_ready_n), .i_analog(analog),
        .o_filt_valid(i_filt_valid), .o_filt_data(i_filt_data), .o_rd_done(i_rd_done));
    task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task cmd(input logic [2:0] code);
        @(posedge i_clk);
        i_ctrl_wr <= 1'b1;
        i_calib_mode_field <= code;
        @(posedge i_clk);
        i_ctrl_wr <= 1'b0;
    endtask
    task coef(input logic ofs, input logic [23:0] v);
        @(posedge i_clk);
        i_ofs_wr <= ofs;
        i_fs_wr <= !ofs;
        i_coef_data <= v;
        @(posedge i_clk);
        i_ofs_wr <= 1'b0;
        i_fs_wr <= 1'b0;
    endtask
    // ready must first be seen high, then low with no calibration running
    task wait_rdy;
        int n;
        n = 0;
        do begin @(posedge i_clk); #1; n++; end while (o_result_ready_n !== 1'b1 && n < 3000);
        do begin
            @(posedge i_clk);
            #1;
            n++;
        end while ((o_result_ready_n !== 1'b0 || o_calibrating !== 1'b0) && n < 3000);
        chk("ready wait", 24'h00_0000, {23'h0, n >= 3000});
    endtask
    task t_reset;
        chk("ready", 24'h00_0001, {23'h0, o_result_ready_n});
        chk("mode", 24'h00_0000, {21'h0, o_calib_mode_field});
        chk("fs", 24'h40_0000, o_fullscale_coef);
        chk("ofs", 24'h00_0000, o_offset_coef);
        @(posedge i_clk);
        i_sync_n <= 1'b0;
        @(posedge i_clk);
        #1;
        chk("sync filter reset", 24'h00_0001, {23'h0, o_filter_rst});
        @(posedge i_clk);
        i_sync_n <= 1'b1;
        #1;
        chk("sync pulse end", 24'h00_0000, {23'h0, o_filter_rst});
        $display("test reset done");
    endtask
    task t_normal;
        coef(1'b1, 24'h00_0100);
        coef(1'b0, 24'h20_0000);
        wait_rdy();
        chk("scaled word", 24'h09_1A00, o_result);
        i_word16 <= 1'b1;
        wait_rdy();
        chk("short word", 24'h00_091A, o_result);
        i_word16 <= 1'b0;
        $display("test normal done");
    endtask
    task t_self;
        analog = 24'h30_0100;
        cmd(3'h1);
        wait_rdy();
        chk("self ofs", 24'h00_0100, o_offset_coef);
        chk("self fs", 24'hAA_AAAA, o_fullscale_coef);
        chk("self word", 24'h7F_FFFF, o_result);
        i_bipolar <= 1'b1;
        cmd(3'h1);
        wait_rdy();
        chk("bip self fs", 24'h55_5555, o_fullscale_coef);
        chk("bip self word", 24'hBF_FFFF, o_result);
        i_bipolar <= 1'b0;
        $display("test self done");
    endtask
    // analog held steady for each step, zero step first
    task t_system;
        analog = 24'h00_0200;
        cmd(3'h2);
        wait_rdy();
        chk("sys zero ofs", 24'h00_0200, o_offset_coef);
        chk("sys zero fs", 24'h55_5555, o_fullscale_coef);
        analog = 24'h50_0200;
        cmd(3'h3);
        wait_rdy();
        chk("sys full fs", 24'hCC_CCCC, o_fullscale_coef);
        chk("sys full word", 24'hFF_FFFF, o_result);
        analog = 24'h00_0100;
        cmd(3'h4);
        wait_rdy();
        chk("sys ofs ofs", 24'h00_0100, o_offset_coef);
        chk("sys ofs fs", 24'hAA_AAAA, o_fullscale_coef);
        chk("sys ofs word", 24'h00_0000, o_result);
        $display("test system done");
    endtask
    task t_backgnd;
        int falls;
        logic prev;
        falls = 0;
        prev = 1'b1;
        analog = 24'h30_0100;
        coef(1'b1, 24'h00_0000);
        coef(1'b0, 24'h40_0000);
        cmd(3'h5);
        repeat (24 * 32 + 16) begin
            @(posedge i_clk);
            #1;
            if (prev === 1'b1 && o_result_ready_n === 1'b0) begin
                falls++;
                if (falls == 1) chk("bg first word", 24'h30_0000, o_result);
            end
            prev = o_result_ready_n;
        end
        chk("bg settled word", 24'h7F_FFFF, o_result);
        chk("bg deliveries", 24'h00_0004, falls[23:0]);
        chk("bg mode", 24'h00_0005, {21'h0, o_calib_mode_field});
        chk("bg ofs", 24'h00_0100, o_offset_coef);
        chk("bg fs", 24'hAA_AAAA, o_fullscale_coef);
        $display("test background done");
    endtask
    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #(40 * 20000);
        mismatches++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        t_reset();
        t_normal();
        t_self();
        t_system();
        t_backgnd();
        end_of_test();
    end
endmodule
